/* File: design/adcrc_clock_divider.v */
// Conversion clock prescaler producing a one-cycle tick
`timescale 1ns/1ps
module adcrc_clock_divider #(
  parameter DIV_W = 3                     // Width of the divide exponent
) (
  input  wire             clk,            // System clock
  input  wire             rst_n,          // Synchronous reset, active low
  input  wire [DIV_W-1:0] divSel,         // Exponent: divide by 2^divSel
  output wire             convTick        // One tick per conversion clock
);
  localparam CNT_W = (1 << DIV_W) - 1;    // Counter wide enough for 2^max

  reg  [CNT_W-1:0] count_ff;              // Free running prescale counter
  wire [CNT_W-1:0] nxt_count;             // Next counter value
  wire [CNT_W-1:0] lowMask;               // Bits that must be all ones

  // ==========================================
  // Counter
  assign nxt_count = count_ff + {{(CNT_W-1){1'b0}}, 1'b1};

  // Free running; the mask picks the period so no reload is needed
  always @(posedge clk) begin
    if (!rst_n) begin
      count_ff <= {CNT_W{1'b0}};
    end else begin
      count_ff <= nxt_count;
    end
  end

  // Tick when the low divSel bits are all ones, so period is 2^divSel
  assign lowMask  = ~({CNT_W{1'b1}} << divSel);
  assign convTick = ((count_ff & lowMask) == lowMask);
endmodule

/* File: design/adcrc_defs.vh */
// Constants for the converter register control block
`ifndef ADCRC_DEFS_VH
`define ADCRC_DEFS_VH

// ==========================================
// Register addresses
`define ADCRC_ADDR_W        4
`define ADCRC_A_RES_LO      4'h0
`define ADCRC_A_RES_HI      4'h1
`define ADCRC_A_CTRL        4'h2
`define ADCRC_A_SRCCLK      4'h3
`define ADCRC_A_REFGAIN     4'h4
`define ADCRC_A_BANDGAP     4'h5
`define ADCRC_A_IRQ_STAT    4'h6
`define ADCRC_A_IRQ_MASK    4'h7

// ==========================================
// Field positions
`define ADCRC_B_START       7
`define ADCRC_B_BUSY        6
`define ADCRC_B_ENABLE      5
`define ADCRC_B_FORMAT      4
`define ADCRC_B_GAINEN      7
`define ADCRC_B_GAININ      4
`define ADCRC_B_BGEN        0

// ==========================================
// Field slices, and single bits inside a field
`define ADCRC_F_CHAN        3:0
`define ADCRC_F_SRC         7:4
`define ADCRC_F_DIV         2:0
`define ADCRC_F_REF         3:2
`define ADCRC_F_GAIN        1:0
`define ADCRC_F_TAP         1:0
`define ADCRC_F_IRQ         1:0
`define ADCRC_B_SRC_TOP     3
`define ADCRC_B_SRC_GAIN    2
`define ADCRC_B_REF_GAIN    1

// ==========================================
// Reset values and write masks
`define ADCRC_RST_BYTE      8'h00
`define ADCRC_SRCCLK_WMASK  8'hF7
`define ADCRC_REFGAIN_WMASK 8'h9F
`define ADCRC_BANDGAP_WMASK 8'h01

// ==========================================
// Reference select codes
`define ADCRC_REF_SUPPLY    2'h0
`define ADCRC_REF_PIN       2'h1

// ==========================================
// Source route one-hot codes
`define ADCRC_RT_EXT        5'h01
`define ADCRC_RT_SUPPLY     5'h02
`define ADCRC_RT_GAIN       5'h04
`define ADCRC_RT_GROUND     5'h08
`define ADCRC_RT_NONE       5'h10

`endif

/* File: design/adcrc_register_control.v */
// Register control for the 12-bit converter: start, busy, routing
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "adcrc_defs.vh"
module adcrc_register_control #(
  parameter NUM_PINS  = 16,               // External analog inputs
  parameter CONV_CLKS = 14                // Conversion clocks per result
) (
  input  wire        clk,                 // System clock
  input  wire        rst_n,               // Synchronous reset, active low
  input  wire [3:0]  regAddr,             // Register address
  input  wire [7:0]  regWrData,           // Write data
  input  wire        regWrEn,             // Write strobe
  input  wire        regRdEn,             // Read strobe
  output reg  [7:0]  regRdData,           // Read data, cycle after strobe
  input  wire [11:0] coreResult,          // Result from analog core
  input  wire [15:0] pinAnalogSel,        // Pin-sharing: pin is analog
  input  wire [15:0] pinPullHighCfg,      // Pull-high configuration
  output reg         converterOn,         // Converter powered
  output reg         convActive,          // Analog core converting
  output wire        convClkTick,         // Conversion clock tick
  output reg  [15:0] channelConnect,      // One-hot external switch
  output reg  [4:0]  sourceRoute,         // One-hot source route
  output reg  [1:0]  supplyTap,           // 0: full, 1: /2, 2: /4
  output reg  [1:0]  gainTap,             // 0: /1, 1: /2, 2: /4
  output reg  [2:0]  referenceRoute,      // Supply, pin, gain amp
  output reg         gainAmpOn,           // Gain amplifier enable
  output reg         gainAmpFromBandgap,  // Gain amp input is bandgap
  output reg  [1:0]  gainAmpGain,         // Gain amp gain code
  output reg         bandgapOn,           // Bandgap reference enable
  output reg  [15:0] pinDigitalOff,       // Remove pin digital function
  output reg  [15:0] pinPullHighOn,       // Effective pull-high enable
  output wire        irqOut               // Level interrupt
);
  // ==========================================
  // State machine codes
  localparam ST_IDLE = 3'b001;            // Waiting for a start
  localparam ST_ARMD = 3'b010;            // Start bit seen high
  localparam ST_CONV = 3'b100;            // Conversion running
  localparam CNT_W   = 5;                 // Conversion counter width
  localparam DIV_W   = 3;                 // Clock exponent width
  // Count loaded at start; CNT_W must hold CONV_CLKS or it wraps
  localparam [CNT_W-1:0] CONV_LOAD = CONV_CLKS[CNT_W-1:0];
  localparam [CNT_W-1:0] CNT_ONE   = {{(CNT_W-1){1'b0}}, 1'b1};

  // ==========================================
  // Registers
  reg  [2:0]  state_ff;                   // Start and conversion sequence
  reg  [2:0]  nxt_state;                  // Next sequence state
  reg  [CNT_W-1:0] convCnt_ff;            // Conversion clocks remaining
  reg  [CNT_W-1:0] nxt_convCnt;           // Next remaining count
  reg         startBit_ff;                // Start bit as written
  reg         busy_ff;                    // Busy flag
  reg         nxt_busy;                   // Next busy flag
  reg         enable_ff;                  // Converter enable bit
  reg         format_ff;                  // Result format select
  reg  [3:0]  channel_ff;                 // External channel field
  reg  [7:0]  srcClk_ff;                  // Source and clock register
  reg  [7:0]  refGain_ff;                 // Reference and gain register
  reg  [7:0]  bandgap_ff;                 // Bandgap control register
  reg  [11:0] result_ff;                  // Stored result
  reg         doneEvt;                    // Conversion just finished
  reg  [1:0]  irqStat_ff;                 // Sticky: done, start ignored
  reg  [1:0]  irqMask_ff;                 // Interrupt mask
  reg         ignoredEvt;                 // Start refused while busy
  wire [7:0]  resLow;                     // Formatted low byte
  wire [7:0]  resHigh;                    // Formatted high byte
  wire [7:0]  ctrlView;                   // Control register read view
  wire        wrCtrl;                     // Control register write
  wire [3:0]  srcField;                   // Signal source field
  wire [1:0]  refField;                   // Reference source field
  wire [DIV_W-1:0] divField;              // Conversion clock exponent
  wire [1:0]  irqEvents;                  // Events that set status bits
  wire [NUM_PINS-1:0] chanOneHot;         // Decoded channel switch
  wire        extSelected;                // Source field picks a pin

  // ==========================================
  // Field views of the stored registers
  assign wrCtrl    = regWrEn && (regAddr == `ADCRC_A_CTRL);
  assign srcField  = srcClk_ff[`ADCRC_F_SRC];
  assign refField  = refGain_ff[`ADCRC_F_REF];
  assign divField  = srcClk_ff[`ADCRC_F_DIV];
  // Status bit 1 is the refused start, bit 0 the finished conversion
  assign irqEvents = {ignoredEvt, doneEvt};
  // Only one switch may close; a wider pin count widens this decode
  assign chanOneHot = {{(NUM_PINS-1){1'b0}}, 1'b1} << channel_ff;
  // Codes 0000, 0100 and 11xx route the external channel
  assign extSelected = srcField[`ADCRC_B_SRC_TOP]
                     ? srcField[`ADCRC_B_SRC_GAIN]
                     : (srcField[`ADCRC_F_TAP] == 2'h0);

  // ==========================================
  // Submodules
  adcrc_clock_divider #(
    .DIV_W    (DIV_W)
  ) uDiv (
    .clk      (clk),
    .rst_n    (rst_n),
    .divSel   (divField),
    .convTick (convClkTick)
  );

  adcrc_result_format uFmt (
    .result    (result_ff),
    .formatSel (format_ff),
    .lowByte   (resLow),
    .highByte  (resHigh)
  );

  // ==========================================
  // Start sequence and conversion state machine
  // The completing write is judged by the enable bit already stored,
  // so enabling and starting in one write starts nothing; software
  // must set the enable bit in an earlier write.
  always @* begin
    nxt_state   = state_ff;
    nxt_convCnt = convCnt_ff;
    nxt_busy    = busy_ff;
    doneEvt     = 1'b0;
    ignoredEvt  = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        // Rising edge of the start bit arms the sequence
        if (wrCtrl && regWrData[`ADCRC_B_START] && !startBit_ff) begin
          nxt_state = ST_ARMD;
        end
      end
      ST_ARMD: begin
        // Falling edge completes low-high-low; needs power on
        if (wrCtrl && !regWrData[`ADCRC_B_START]) begin
          if (enable_ff) begin
            nxt_state   = ST_CONV;
            nxt_busy    = 1'b1;
            nxt_convCnt = CONV_LOAD;
          end else begin
            // Enable was off: the start is dropped
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_CONV: begin
        // Any start attempt here is dropped
        if (wrCtrl && regWrData[`ADCRC_B_START] && !startBit_ff) begin
          ignoredEvt = 1'b1;
        end
        if (!enable_ff) begin
          // Power down aborts; result bytes stay as they were
          nxt_state = ST_IDLE;
          nxt_busy  = 1'b0;
        end else if (convClkTick) begin
          // One step per conversion clock; the last one finishes
          if (convCnt_ff == CNT_ONE) begin
            nxt_state = ST_IDLE;
            nxt_busy  = 1'b0;
            doneEvt   = 1'b1;
          end else begin
            nxt_convCnt = convCnt_ff - CNT_ONE;
          end
        end
      end
      default: begin
        // Illegal code: return to idle and drop busy
        nxt_state = ST_IDLE;
        nxt_busy  = 1'b0;
      end
    endcase
  end

  // ==========================================
  // Sequence registers
  // Counter and busy flag move together, so busy never lags the count
  always @(posedge clk) begin
    if (!rst_n) begin
      state_ff   <= ST_IDLE;
      convCnt_ff <= {CNT_W{1'b0}};
      busy_ff    <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      convCnt_ff <= nxt_convCnt;
      busy_ff    <= nxt_busy;
    end
  end

  // ==========================================
  // Result store: loaded as busy falls, frozen while disabled
  // An aborted conversion never loads, so the old bytes stay
  // readable after a power down in mid-conversion
  always @(posedge clk) begin
    if (!rst_n) begin
      result_ff <= 12'h000;
    end else if (doneEvt && enable_ff) begin
      result_ff <= coreResult;
    end
  end

  // ==========================================
  // Software writable registers
  // The start bit is kept so that only a low-to-high write arms the
  // sequence; rewriting a high start bit does not arm again.
  always @(posedge clk) begin
    if (!rst_n) begin
      // All control fields clear at reset
      startBit_ff <= 1'b0;
      enable_ff   <= 1'b0;
      format_ff   <= 1'b0;
      channel_ff  <= 4'h0;
      srcClk_ff   <= `ADCRC_RST_BYTE;
      refGain_ff  <= `ADCRC_RST_BYTE;
      bandgap_ff  <= `ADCRC_RST_BYTE;
      irqMask_ff  <= 2'h0;
    end else if (regWrEn) begin
      case (regAddr)
        `ADCRC_A_CTRL: begin
          // Busy bit is read only; a written value is discarded
          startBit_ff <= regWrData[`ADCRC_B_START];
          enable_ff   <= regWrData[`ADCRC_B_ENABLE];
          format_ff   <= regWrData[`ADCRC_B_FORMAT];
          channel_ff  <= regWrData[`ADCRC_F_CHAN];
        end
        `ADCRC_A_SRCCLK: begin
          // Bit 3 is not implemented; the mask keeps it zero
          srcClk_ff <= regWrData & `ADCRC_SRCCLK_WMASK;
        end
        `ADCRC_A_REFGAIN: begin
          // Bits 6 and 5 are not implemented
          refGain_ff <= regWrData & `ADCRC_REFGAIN_WMASK;
        end
        `ADCRC_A_BANDGAP: begin
          // Only the enable bit exists here
          bandgap_ff <= regWrData & `ADCRC_BANDGAP_WMASK;
        end
        `ADCRC_A_IRQ_MASK: begin
          irqMask_ff <= regWrData[`ADCRC_F_IRQ];
        end
        default: begin
          // Status clears in its own block; other addresses hold nothing writable
        end
      endcase
    end
  end

  // ==========================================
  // Interrupt status: set wins over write-one-to-clear
  // A clear that meets a new event keeps the bit set, so software
  // never loses a completion that lands during its own clear.
  always @(posedge clk) begin
    if (!rst_n) begin
      irqStat_ff <= 2'h0;
    end else begin
      if (regWrEn && regAddr == `ADCRC_A_IRQ_STAT) begin
        irqStat_ff <= (irqStat_ff & ~regWrData[`ADCRC_F_IRQ]) | irqEvents;
      end else begin
        // No clear this cycle: events only accumulate
        irqStat_ff <= irqStat_ff | irqEvents;
      end
    end
  end

  // Level output, high while any unmasked status bit is set
  assign irqOut = |(irqStat_ff & irqMask_ff);

  // ==========================================
  // Read port: data valid the cycle after the strobe only
  // Returning zero outside the data cycle keeps a stale value from
  // being mistaken for a fresh read
  assign ctrlView = {startBit_ff, busy_ff, enable_ff, format_ff, channel_ff};

  always @(posedge clk) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      case (regAddr)
        `ADCRC_A_RES_LO:   regRdData <= resLow;
        `ADCRC_A_RES_HI:   regRdData <= resHigh;
        `ADCRC_A_CTRL:     regRdData <= ctrlView;
        `ADCRC_A_SRCCLK:   regRdData <= srcClk_ff;
        `ADCRC_A_REFGAIN:  regRdData <= refGain_ff;
        `ADCRC_A_BANDGAP:  regRdData <= bandgap_ff;
        `ADCRC_A_IRQ_STAT: regRdData <= {6'h00, irqStat_ff};
        `ADCRC_A_IRQ_MASK: regRdData <= {6'h00, irqMask_ff};
        default:           regRdData <= 8'h00;
      endcase
    end else begin
      // Between reads the bus shows zero
      regRdData <= 8'h00;
    end
  end

  // ==========================================
  // Analog routing controls, registered to avoid switch glitches
  // One cycle of latency is traded for switches that never chatter
  always @(posedge clk) begin
    if (!rst_n) begin
      converterOn        <= 1'b0;
      convActive         <= 1'b0;
      channelConnect     <= 16'h0000;
      sourceRoute        <= `ADCRC_RT_NONE;
      supplyTap          <= 2'h0;
      gainTap            <= 2'h0;
      referenceRoute     <= 3'h0;
      gainAmpOn          <= 1'b0;
      gainAmpFromBandgap <= 1'b0;
      gainAmpGain        <= 2'h0;
      bandgapOn          <= 1'b0;
      pinDigitalOff      <= 16'h0000;
      pinPullHighOn      <= 16'h0000;
    end else begin
      converterOn        <= enable_ff;
      convActive         <= busy_ff;
      gainAmpOn          <= refGain_ff[`ADCRC_B_GAINEN];
      gainAmpFromBandgap <= refGain_ff[`ADCRC_B_GAININ];
      gainAmpGain        <= refGain_ff[`ADCRC_F_GAIN];
      bandgapOn          <= bandgap_ff[`ADCRC_B_BGEN];
      // Digital function and pull-high follow the pin-sharing setting
      pinDigitalOff      <= pinAnalogSel;
      pinPullHighOn      <= pinPullHighCfg & ~pinAnalogSel;
      // Reference source decode
      if (refField[`ADCRC_B_REF_GAIN]) begin
        referenceRoute <= 3'b100;
      end else if (refField == `ADCRC_REF_PIN) begin
        referenceRoute <= 3'b010;
      end else begin
        referenceRoute <= 3'b001;
      end
      // Source decode; internal choices open the channel switch
      // Taps only matter while their route is the chosen one
      supplyTap <= srcField[`ADCRC_F_TAP] - 2'h1;
      gainTap   <= srcField[`ADCRC_F_TAP] - 2'h1;
      if (extSelected) begin
        sourceRoute <= `ADCRC_RT_EXT;
      end else if (srcField[`ADCRC_B_SRC_TOP]) begin
        sourceRoute <= `ADCRC_RT_GROUND;
      end else if (srcField[`ADCRC_B_SRC_GAIN]) begin
        sourceRoute <= `ADCRC_RT_GAIN;
      end else begin
        sourceRoute <= `ADCRC_RT_SUPPLY;
      end
      // Ground and internal sources keep every channel switch open
      if (extSelected) begin
        channelConnect <= chanOneHot;
      end else begin
        channelConnect <= 16'h0000;
      end
    end
  end
endmodule

/* File: design/adcrc_result_format.v */
// Places a 12-bit result into the two readable result bytes
`timescale 1ns/1ps
module adcrc_result_format (
  input  wire [11:0] result,              // Stored conversion result
  input  wire        formatSel,           // Result format select bit
  output wire [7:0]  lowByte,             // Result low byte view
  output wire [7:0]  highByte             // Result high byte view
);
  // ==========================================
  // Alignment; unused positions are forced to zero
  assign highByte = formatSel ? {4'h0, result[11:8]}
                              : result[11:4];
  assign lowByte  = formatSel ? result[7:0]
                              : {result[3:0], 4'h0};
endmodule

/* File: test/adc_register_control_bench.sv */
// Self-checking bench for the converter register control block
`timescale 1ns/1ps
`include "adcrc_defs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module adc_register_control_bench;
  localparam CONV = 4;                 // Short conversion for run time
  reg clk = 1'b0, rst_n = 1'b0;        // Clock and reset
  reg [3:0] regAddr = 4'h0;            // Bus address
  reg [7:0] regWrData = 8'h00;         // Bus write data
  reg regWrEn = 1'b0, regRdEn = 1'b0;  // Bus strobes
  reg [11:0] coreResult = 12'hA5C;     // Core result
  reg [15:0] pinAnalogSel = 16'h00F0;  // Analog pins
  reg [15:0] pinPullHighCfg = 16'h0FF0;// Pull-high setting
  wire [7:0] regRdData;                // Read data
  wire [15:0] channelConnect, pinDigitalOff, pinPullHighOn;
  wire [4:0] sourceRoute;              // Source route
  wire [1:0] supplyTap, gainTap;       // Taps
  wire [2:0] referenceRoute;           // Reference route
  wire converterOn, convActive, convClkTick, irqOut, bandgapOn;
  wire gainAmpOn, gainAmpFromBandgap;  // Gain amp controls
  wire [1:0] gainAmpGain;              // Gain amp gain code
  integer failures = 0, compares = 0, i, n, t0;
  reg [4:0] rt;                        // Expected route
  always #50 clk = ~clk;
  adcrc_register_control #(.CONV_CLKS(CONV)) dut (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .coreResult(coreResult), .pinAnalogSel(pinAnalogSel),
    .pinPullHighCfg(pinPullHighCfg), .converterOn(converterOn),
    .convActive(convActive), .convClkTick(convClkTick),
    .channelConnect(channelConnect), .sourceRoute(sourceRoute),
    .supplyTap(supplyTap), .gainTap(gainTap),
    .referenceRoute(referenceRoute), .gainAmpOn(gainAmpOn),
    .gainAmpFromBandgap(gainAmpFromBandgap), .gainAmpGain(gainAmpGain),
    .bandgapOn(bandgapOn),
    .pinDigitalOff(pinDigitalOff), .pinPullHighOn(pinPullHighOn),
    .irqOut(irqOut));
  // ==========================================
  // Bus tasks: strobe one cycle, data in the next
  task wr(input [3:0] a, input [7:0] d);
    @(posedge clk);
    regAddr <= a; regWrData <= d; regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    // Routing outputs are registered once more: let them settle
    @(posedge clk) #1;
  endtask
  task rd(input [3:0] a, input [7:0] e);
    @(posedge clk);
    regAddr <= a; regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1 `CHK(regRdData, e)
  endtask
  task complete_run;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Start sequence, optional second start mid-run; time in cycles
  task conv(input [7:0] c, input mid, input integer lo, input integer hi);
    wr(`ADCRC_A_CTRL, c | 8'hA0);
    wr(`ADCRC_A_CTRL, c | 8'h20);
    `CHK(convActive, 1'b1)
    t0 = $time;
    if (mid) begin
      wr(`ADCRC_A_CTRL, c | 8'hA0);
      wr(`ADCRC_A_CTRL, c | 8'h20);
    end
    for (n = 0; n < 2000 && convActive; n++) @(posedge clk) #1;
    n = ($time - t0) / 100;
    if (n < lo || n > hi) begin
      failures++;
      $display("unexpected at %0t: conversion took %0d", $time, n);
    end
  endtask
  // Period of the conversion clock tick, in system clocks
  task tick(input [2:0] d);
    wr(`ADCRC_A_SRCCLK, {5'h00, d});
    for (n = 0; n < 300 && !convClkTick; n++) @(posedge clk) #1;
    @(posedge clk) #1;
    for (n = 1; n < 300 && !convClkTick; n++) @(posedge clk) #1;
    `CHK(n, 1 << d)
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 16; i++) rd(i, 8'h00);  // Reset values, unmapped
    wr(`ADCRC_A_SRCCLK, 8'hFF); rd(`ADCRC_A_SRCCLK, 8'hF7);
    wr(`ADCRC_A_REFGAIN, 8'hFF); rd(`ADCRC_A_REFGAIN, 8'h9F);
    `CHK(gainAmpOn, 1'b1)
    `CHK(gainAmpFromBandgap, 1'b1)
    `CHK(gainAmpGain, 2'h3)
    wr(`ADCRC_A_BANDGAP, 8'hFF); rd(`ADCRC_A_BANDGAP, 8'h01);
    `CHK(bandgapOn, 1'b1)
    wr(`ADCRC_A_BANDGAP, 8'h00); `CHK(bandgapOn, 1'b0)
    `CHK(pinPullHighOn, 16'h0F00)
    `CHK(pinDigitalOff, 16'h00F0)
    for (i = 0; i < 4; i++) begin
      wr(`ADCRC_A_REFGAIN, i << 2);
      `CHK(referenceRoute, (i < 2) ? (3'h1 << i) : 3'h4)
    end
    wr(`ADCRC_A_CTRL, 8'h25);
    `CHK(converterOn, 1'b1)
    for (i = 0; i < 16; i++) begin
      wr(`ADCRC_A_SRCCLK, i << 4);
      rt = (i == 0 || i == 4 || i >= 12) ? `ADCRC_RT_EXT :
           (i < 4) ? `ADCRC_RT_SUPPLY : (i < 8) ? `ADCRC_RT_GAIN :
           `ADCRC_RT_GROUND;
      `CHK(sourceRoute, rt)
      `CHK(channelConnect, (rt == `ADCRC_RT_EXT) ? 16'h0020 : 16'h0)
      if (rt == `ADCRC_RT_SUPPLY) `CHK(supplyTap, i[1:0] - 2'h1)
      if (rt == `ADCRC_RT_GAIN) `CHK(gainTap, i[1:0] - 2'h1)
    end
    for (i = 0; i < 16; i++) begin
      wr(`ADCRC_A_CTRL, 8'h20 | i);
      `CHK(channelConnect, 16'h0001 << i)
    end
    tick(3'h0); tick(3'h3); tick(3'h7);
    wr(`ADCRC_A_CTRL, 8'h80); wr(`ADCRC_A_CTRL, 8'h00);
    `CHK(convActive, 1'b0)
    `CHK(converterOn, 1'b0)
    wr(`ADCRC_A_SRCCLK, 8'h00);
    wr(`ADCRC_A_CTRL, 8'h20);
    wr(`ADCRC_A_CTRL, 8'h60); rd(`ADCRC_A_CTRL, 8'h20);
    conv(8'h00, 1'b0, CONV - 1, CONV + 1);
    rd(`ADCRC_A_RES_HI, 8'hA5); rd(`ADCRC_A_RES_LO, 8'hC0);
    wr(`ADCRC_A_CTRL, 8'h30);
    rd(`ADCRC_A_RES_HI, 8'h0A); rd(`ADCRC_A_RES_LO, 8'h5C);
    `CHK(irqOut, 1'b0)
    wr(`ADCRC_A_IRQ_MASK, 8'h01); `CHK(irqOut, 1'b1)
    wr(`ADCRC_A_IRQ_STAT, 8'h01); `CHK(irqOut, 1'b0)
    @(posedge clk) coreResult <= 12'h3E7;
    wr(`ADCRC_A_SRCCLK, 8'h03);
    conv(8'h10, 1'b1, 8 * CONV - 8, 8 * CONV + 1);
    rd(`ADCRC_A_IRQ_STAT, 8'h03);
    rd(`ADCRC_A_RES_LO, 8'hE7); rd(`ADCRC_A_RES_HI, 8'h03);
    wr(`ADCRC_A_CTRL, 8'h10);
    @(posedge clk) coreResult <= 12'h124;
    rd(`ADCRC_A_RES_LO, 8'hE7); rd(`ADCRC_A_RES_HI, 8'h03);
    wr(`ADCRC_A_CTRL, 8'h00); rd(`ADCRC_A_RES_HI, 8'h3E);
    rd(`ADCRC_A_RES_LO, 8'h70);
    complete_run;
  end
endmodule

/* File: test/adcrc_register_control_chk.sv */
// Port-level assertions for the converter register control block
`timescale 1ns/1ps
`include "adcrc_defs.vh"
module adcrc_register_control_chk (
  input wire        clk,             // System clock
  input wire        rst_n,           // Synchronous reset, active low
  input wire [3:0]  regAddr,         // Register address
  input wire        regRdEn,         // Read strobe
  input wire [7:0]  regRdData,       // Read data
  input wire [15:0] pinAnalogSel,    // Pin is analog
  input wire [15:0] pinPullHighCfg,  // Pull-high setting
  input wire        converterOn,     // Converter powered
  input wire        convActive,      // Converting
  input wire [15:0] channelConnect,  // External switch
  input wire [4:0]  sourceRoute,     // Source route
  input wire [1:0]  supplyTap,       // Supply divider tap
  input wire [2:0]  referenceRoute,  // Reference route
  input wire [15:0] pinDigitalOff,   // Digital function removed
  input wire [15:0] pinPullHighOn,   // Effective pull-high
  input wire        irqOut           // Interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Read sequences: strobe, then data one cycle later
  sequence rdSrc;
    regRdEn && regAddr == `ADCRC_A_SRCCLK;
  endsequence
  sequence rdFree;
    regRdEn && regAddr[3];
  endsequence
  // ==========================================
  // Assertions
  pull_drop_a : assert property ($past(rst_n) |-> pinPullHighOn ==
    ($past(pinPullHighCfg) & ~$past(pinAnalogSel)))
    else $error("pull-high not dropped on analog pin");
  pin_remove_a : assert property ($past(rst_n) |->
    pinDigitalOff == $past(pinAnalogSel))
    else $error("digital function kept on analog pin");
  chan_onehot_a : assert property ($onehot0(channelConnect))
    else $error("more than one channel connected");
  ext_off_a : assert property (sourceRoute != `ADCRC_RT_EXT |->
    channelConnect == 16'h0000)
    else $error("external path joined internal source");
  src_bit3_a : assert property (rdSrc |=> !regRdData[3])
    else $error("source register bit 3 not zero");
  free_zero_a : assert property (rdFree |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  busy_power_a : assert property ($rose(convActive) |-> converterOn)
    else $error("conversion while powered down");
  tap_range_a : assert property (sourceRoute == `ADCRC_RT_SUPPLY |->
    supplyTap != 2'h3)
    else $error("bad supply tap");
  ref_onehot_a : assert property ($onehot0(referenceRoute))
    else $error("two references selected");
  irq_reset_a : assert property ($past(!rst_n) |-> !irqOut)
    else $error("interrupt high after reset");
endmodule
bind adcrc_register_control adcrc_register_control_chk chk (
  .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regRdEn(regRdEn),
  .regRdData(regRdData), .pinAnalogSel(pinAnalogSel),
  .pinPullHighCfg(pinPullHighCfg), .converterOn(converterOn),
  .convActive(convActive), .channelConnect(channelConnect),
  .sourceRoute(sourceRoute), .supplyTap(supplyTap),
  .referenceRoute(referenceRoute), .pinDigitalOff(pinDigitalOff),
  .pinPullHighOn(pinPullHighOn), .irqOut(irqOut));
